// ### logic/pwr_clk_ctrl.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module pwr_clk_ctrl
#(
  parameter int ADDR_W = 4
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [pwr_clk_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pwr_clk_pkg::DATA_W-1:0] rdata,
  input wire logic low_osc_clk_in,
  input wire logic high_osc_clk_in,
  input wire logic supply_ok_in,
  output logic cpu_clk,
  output logic cpu_clock_select,
  output logic high_osc_enable,
  output logic osc_regulator_level,
  output logic doubler_on,
  output logic halver_on,
  output logic core_supply_select,
  output logic lcd_supply_select,
  output logic lcd_power_on,
  output logic detector_on
);
  import pwr_clk_pkg::*;

  if (ADDR_W < 2)
  begin : g_addr_w_check
    $error("ADDR_W too small for the register map");
  end

  typedef struct packed {
    logic [DATA_W-1:0] clock;
    logic [DATA_W-1:0] supply;
    logic [DATA_W-1:0] aux;
    logic supply_ok;
    logic [DATA_W-1:0] rdata;
  } ctrl_s;

  ctrl_s q;
  ctrl_s d;
  logic mux_out;
  logic mux_on_high;
  logic mux_pending;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  // ****************************************
  // register file
  // ****************************************
  always_comb
  begin
    d = q;
    if (q.aux[BIT_DETECTOR_ON])
      d.supply_ok = supply_ok_in;
    if (wr && hit(addr, OFS_CLOCK))
      d.clock = {1'b0, wdata[2:0]};
    if (wr && hit(addr, OFS_SUPPLY))
      d.supply = wdata;
    if (wr && hit(addr, OFS_AUX))
      d.aux = {2'b00, wdata[1:0]};
    d.rdata = RST_RDATA;
    if (rd)
    begin
      if (hit(addr, OFS_CLOCK))
        d.rdata = q.clock;
      else if (hit(addr, OFS_SUPPLY))
        d.rdata = q.supply;
      else if (hit(addr, OFS_AUX))
        d.rdata = q.aux;
      else if (hit(addr, OFS_STATUS))
      begin
        d.rdata[BIT_CLOCK_ON_HIGH] = mux_on_high;
        d.rdata[BIT_SWITCH_PENDING] = mux_pending;
        d.rdata[BIT_SUPPLY_OK] = q.supply_ok;
      end
      else
        d.rdata = RST_RDATA;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '{clock: RST_CLOCK, supply: RST_SUPPLY, aux: RST_AUX,
             supply_ok: 1'b0, rdata: RST_RDATA};
    end
    else
      q <= d;
  end

  // ****************************************
  // clock selector
  // ****************************************
  glitchless_clk_mux u_mux
  (
    .mclk(mclk),
    .arst_n(arst_n),
    .low_src(low_osc_clk_in),
    .high_src(high_osc_clk_in),
    .sel_req(q.clock[BIT_CPU_CLOCK_SELECT]),
    .clk_out(mux_out),
    .on_high(mux_on_high),
    .pending(mux_pending)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign rdata = q.rdata;
  assign cpu_clk = mux_out;
  assign cpu_clock_select = q.clock[BIT_CPU_CLOCK_SELECT];
  assign high_osc_enable = q.clock[BIT_HIGH_OSC_ENABLE];
  assign osc_regulator_level = q.clock[BIT_OSC_REGULATOR_LEVEL];
  assign doubler_on = q.supply[BIT_DOUBLER_ON];
  assign halver_on = q.supply[BIT_HALVER_ON];
  assign core_supply_select = q.supply[BIT_CORE_SUPPLY_SELECT];
  assign lcd_supply_select = q.supply[BIT_LCD_SUPPLY_SELECT];
  assign lcd_power_on = q.aux[BIT_LCD_POWER_ON];
  assign detector_on = q.aux[BIT_DETECTOR_ON];

  // ****************************************
  // checks
  // ****************************************
  logic first_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      first_q <= 1'b1;
    else
      first_q <= 1'b0;
  end

  property p_rst_cpu_clock;
    @(posedge mclk) disable iff (!arst_n)
      first_q |-> !cpu_clock_select && !mux_on_high;
  endproperty
  a_rst_cpu_clock: assert property (p_rst_cpu_clock)
    else $error("cpu clock not low after reset");

  property p_rst_high_osc;
    @(posedge mclk) disable iff (!arst_n)
      first_q |-> !high_osc_enable;
  endproperty
  a_rst_high_osc: assert property (p_rst_high_osc)
    else $error("high osc on after reset");

  property p_rst_regulator;
    @(posedge mclk) disable iff (!arst_n)
      first_q |-> !osc_regulator_level;
  endproperty
  a_rst_regulator: assert property (p_rst_regulator)
    else $error("regulator not low after reset");

  property p_rst_supply;
    @(posedge mclk) disable iff (!arst_n)
      first_q |-> !doubler_on && !halver_on && !core_supply_select && !lcd_supply_select
                  && !lcd_power_on && !detector_on;
  endproperty
  a_rst_supply: assert property (p_rst_supply)
    else $error("supply bits not clear after reset");

  property p_write_acts;
    @(posedge mclk) disable iff (!arst_n)
      (wr && hit(addr, OFS_SUPPLY)) |=>
        ({lcd_supply_select, core_supply_select, halver_on, doubler_on} == $past(wdata));
  endproperty
  a_write_acts: assert property (p_write_acts)
    else $error("write did not act next cycle");

  property p_read_back;
    @(posedge mclk) disable iff (!arst_n)
      (rd && hit(addr, OFS_CLOCK)) |=>
        (rdata[2:0] == $past({osc_regulator_level, high_osc_enable, cpu_clock_select}));
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data mismatch");

  property p_read_one_cycle;
    @(posedge mclk) disable iff (!arst_n)
      !rd |=> (rdata == RST_RDATA);
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle)
    else $error("read data outside its cycle");

  property p_clock_write;
    @(posedge mclk) disable iff (!arst_n)
      (wr && hit(addr, OFS_CLOCK)) |=>
        ({osc_regulator_level, high_osc_enable, cpu_clock_select} == $past(wdata[2:0]));
  endproperty
  a_clock_write: assert property (p_clock_write)
    else $error("clock write did not act next cycle");

  property p_aux_write;
    @(posedge mclk) disable iff (!arst_n)
      (wr && hit(addr, OFS_AUX)) |=> ({detector_on, lcd_power_on} == $past(wdata[1:0]));
  endproperty
  a_aux_write: assert property (p_aux_write)
    else $error("aux write did not act next cycle");

  property p_unmapped_read;
    @(posedge mclk) disable iff (!arst_n)
      (rd && !hit(addr, OFS_CLOCK) && !hit(addr, OFS_SUPPLY) && !hit(addr, OFS_AUX)
       && !hit(addr, OFS_STATUS)) |=> (rdata == RST_RDATA);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_pending_low;
    @(posedge mclk) disable iff (!arst_n)
      mux_pending |-> !cpu_clk;
  endproperty
  a_pending_low: assert property (p_pending_low)
    else $error("cpu clock high while switching");

  property p_ok_kept;
    @(posedge mclk) disable iff (!arst_n)
      !detector_on |=> $stable(q.supply_ok);
  endproperty
  a_ok_kept: assert property (p_ok_kept)
    else $error("detector result changed while off");

  c_to_high: cover property (@(posedge mclk) disable iff (!arst_n) $rose(mux_on_high));
  c_doubler: cover property (@(posedge mclk) disable iff (!arst_n)
    doubler_on ##1 lcd_supply_select);
  c_detector: cover property (@(posedge mclk) disable iff (!arst_n)
    detector_on ##1 !detector_on);

endmodule // pwr_clk_ctrl

`default_nettype wire

// ### logic/pwr_clk_pkg.sv

`default_nettype none

package pwr_clk_pkg;

  localparam int DATA_W = 4;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] OFS_CLOCK = 4'h0;
  localparam logic [3:0] OFS_SUPPLY = 4'h1;
  localparam logic [3:0] OFS_AUX = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_CPU_CLOCK_SELECT = 0;
  localparam int BIT_HIGH_OSC_ENABLE = 1;
  localparam int BIT_OSC_REGULATOR_LEVEL = 2;
  localparam int BIT_DOUBLER_ON = 0;
  localparam int BIT_HALVER_ON = 1;
  localparam int BIT_CORE_SUPPLY_SELECT = 2;
  localparam int BIT_LCD_SUPPLY_SELECT = 3;
  localparam int BIT_LCD_POWER_ON = 0;
  localparam int BIT_DETECTOR_ON = 1;
  localparam int BIT_CLOCK_ON_HIGH = 0;
  localparam int BIT_SWITCH_PENDING = 1;
  localparam int BIT_SUPPLY_OK = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] RST_CLOCK = 4'h0;
  localparam logic [3:0] RST_SUPPLY = 4'h0;
  localparam logic [3:0] RST_AUX = 4'h0;
  localparam logic [3:0] RST_RDATA = 4'h0;

endpackage

`default_nettype wire

// ### logic/glitchless_clk_mux.sv
`timescale 1ns/100ps
`default_nettype none

module glitchless_clk_mux
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic low_src,
  input wire logic high_src,
  input wire logic sel_req,
  output logic clk_out,
  output logic on_high,
  output logic pending
);

  typedef enum logic [1:0] {ST_RUN, ST_HOLD} mux_state_e;

  typedef struct packed {
    mux_state_e st;
    logic sel;
    logic prev_low;
    logic prev_high;
    logic out;
  } mux_s;

  mux_s q;
  mux_s d;
  logic cur_src;
  logic new_src;
  logic cur_fall;
  logic new_fall;

  // ****************************************
  // switch at falling edges only
  // ****************************************
  always_comb
  begin
    cur_src = q.sel ? high_src : low_src;
    new_src = q.sel ? low_src : high_src;
    cur_fall = (q.sel ? q.prev_high : q.prev_low) && !cur_src;
    new_fall = (q.sel ? q.prev_low : q.prev_high) && !new_src;
    d = q;
    d.prev_low = low_src;
    d.prev_high = high_src;
    case (q.st)
      ST_RUN:
      begin
        d.out = cur_src;
        if ((sel_req != q.sel) && cur_fall)
        begin
          d.st = ST_HOLD;
          d.out = 1'b0;
        end
      end
      ST_HOLD:
      begin
        d.out = 1'b0;
        if (new_fall)
        begin
          d.sel = ~q.sel;
          d.st = ST_RUN;
        end
      end
      default:
      begin
        d.st = ST_RUN;
        d.out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '{st: ST_RUN, sel: 1'b0, prev_low: 1'b0, prev_high: 1'b0, out: 1'b0};
    else
      q <= d;
  end

  assign clk_out = q.out;
  assign on_high = q.sel;
  assign pending = (q.st == ST_HOLD);

  // ****************************************
  // checks
  // ****************************************
  property p_hold_low;
    @(posedge mclk) disable iff (!arst_n)
      (q.st == ST_HOLD) |=> !q.out;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("output not low while switching");

  property p_rise_follows_src;
    @(posedge mclk) disable iff (!arst_n)
      $rose(q.out) |-> ($past(q.sel) ? $past(high_src) : $past(low_src));
  endproperty
  a_rise_follows_src: assert property (p_rise_follows_src)
    else $error("rise not from source");

  c_switch_done: cover property (@(posedge mclk) disable iff (!arst_n)
    (q.st == ST_HOLD) ##1 (q.st == ST_RUN));

endmodule // glitchless_clk_mux

`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import pwr_clk_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic low_osc_clk_in = 1'b0;
  logic high_osc_clk_in = 1'b0;
  logic supply_ok_in = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic cpu_clk, cpu_clock_select, high_osc_enable, osc_regulator_level;
  logic doubler_on, halver_on, core_supply_select, lcd_supply_select;
  logic lcd_power_on, detector_on;
  logic [3:0] clock_vec;
  logic [3:0] supply_vec;
  logic [3:0] aux_vec;
  logic prev_clk = 1'b0;
  logic mon = 1'b0;
  int errors = 0;
  int n_tests = 0;
  int lc = 0;
  int hc = 0;
  int run = 0;
  assign clock_vec = {1'b0, osc_regulator_level, high_osc_enable, cpu_clock_select};
  assign supply_vec = {lcd_supply_select, core_supply_select, halver_on, doubler_on};
  assign aux_vec = {2'b00, detector_on, lcd_power_on};

  pwr_clk_ctrl uut
  (
    .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .low_osc_clk_in(low_osc_clk_in), .high_osc_clk_in(high_osc_clk_in),
    .supply_ok_in(supply_ok_in), .cpu_clk(cpu_clk), .cpu_clock_select(cpu_clock_select),
    .high_osc_enable(high_osc_enable), .osc_regulator_level(osc_regulator_level),
    .doubler_on(doubler_on), .halver_on(halver_on),
    .core_supply_select(core_supply_select), .lcd_supply_select(lcd_supply_select),
    .lcd_power_on(lcd_power_on), .detector_on(detector_on)
  );

  always #10 mclk = ~mclk;

  // ****************************************
  // oscillator sources and phase monitor
  // ****************************************
  always @(posedge mclk)
  begin
    lc = (lc == 7) ? 0 : lc + 1;
    hc = (hc == 2) ? 0 : hc + 1;
    if (lc == 0) low_osc_clk_in <= ~low_osc_clk_in;
    if (hc == 0) high_osc_clk_in <= ~high_osc_clk_in;
    if (cpu_clk === prev_clk) run = run + 1;
    else
    begin
      if (mon) chk("phase_len", 4'h1, {3'b000, run >= 3});
      run = 1;
    end
    prev_clk = cpu_clk;
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [3:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [3:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(nm, exp, rdata);
    @(posedge mclk);
    #1;
    chk("rdata_idle", 4'h0, rdata);
  endtask

  task automatic end_sim;
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk("clock_out", RST_CLOCK, clock_vec);
    chk("supply_out", RST_SUPPLY, supply_vec);
    chk("aux_out", RST_AUX, aux_vec);
    rd_chk("clock_rd", OFS_CLOCK, 4'h0);
    rd_chk("supply_rd", OFS_SUPPLY, 4'h0);
    rd_chk("aux_rd", OFS_AUX, 4'h0);
    rd_chk("status_rd", OFS_STATUS, 4'h0);
  endtask

  task automatic t_regs;
    wr_reg(OFS_SUPPLY, 4'h1);
    chk("supply_out", 4'h1, supply_vec);
    rd_chk("supply_rd", OFS_SUPPLY, 4'h1);
    wr_reg(OFS_SUPPLY, 4'hd);
    chk("supply_out", 4'hd, supply_vec);
    rd_chk("supply_rd", OFS_SUPPLY, 4'hd);
    wr_reg(OFS_CLOCK, 4'he);
    chk("clock_out", 4'h6, clock_vec);
    rd_chk("clock_rd", OFS_CLOCK, 4'h6);
    wr_reg(OFS_AUX, 4'hf);
    chk("aux_out", 4'h3, aux_vec);
    rd_chk("aux_rd", OFS_AUX, 4'h3);
    wr_reg(4'h7, 4'hf);
    chk("supply_kept", 4'hd, supply_vec);
    chk("clock_kept", 4'h6, clock_vec);
    rd_chk("unmapped_rd", 4'h7, 4'h0);
  endtask

  task automatic t_switch;
    wr_reg(OFS_CLOCK, 4'h7);
    repeat (60) @(posedge mclk);
    chk("clock_out", 4'h7, clock_vec);
    rd_chk("on_high", OFS_STATUS, 4'h1);
    wr_reg(OFS_CLOCK, 4'h6);
    wr_reg(OFS_CLOCK, 4'h4);
    chk("clock_out", 4'h4, clock_vec);
    repeat (60) @(posedge mclk);
    rd_chk("on_low", OFS_STATUS, 4'h0);
  endtask

  task automatic t_detect;
    wr_reg(OFS_AUX, 4'h2);
    @(posedge mclk);
    supply_ok_in <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_chk("supply_ok", OFS_STATUS, 4'h4);
    wr_reg(OFS_AUX, 4'h0);
    chk("aux_out", 4'h0, aux_vec);
    @(posedge mclk);
    supply_ok_in <= 1'b0;
    repeat (2) @(posedge mclk);
    rd_chk("supply_kept", OFS_STATUS, 4'h4);
  endtask

  task automatic t_modes;
    wr_reg(OFS_SUPPLY, 4'h1);
    chk("supply_out", 4'h1, supply_vec);
    wr_reg(OFS_SUPPLY, 4'h0);
    chk("supply_out", 4'h0, supply_vec);
    wr_reg(OFS_SUPPLY, 4'h2);
    chk("supply_out", 4'h2, supply_vec);
    wr_reg(OFS_SUPPLY, 4'ha);
    chk("supply_out", 4'ha, supply_vec);
    chk("clock_out", 4'h4, clock_vec);
    rd_chk("supply_rd", OFS_SUPPLY, 4'ha);
  endtask

  initial
  begin
    #100000;
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_regs();
    mon = 1'b1;
    t_switch();
    t_detect();
    t_modes();
    mon = 1'b0;
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    end_sim();
  end
endmodule // tb_top

`default_nettype wire
